// ### rtl/erai_top.sv
// E1 receive alarm change detection, clear-on-read event flags and
// interrupt request, with an Avalon-MM slave for the registers.
// Assumes event inputs come from framer logic on the same clock.
`timescale 1ns/1ps
module erai_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ais_state,
   input wire logic nonfas_valid,
   input wire logic nonfas_a_bit,
   input wire logic [4:0] nonfas_sa_bits,
   input wire logic mfas_valid,
   input wire logic mfas_error,
   input wire logic sig_valid,
   input wire logic [4:0] sig_chan,
   input wire logic [3:0] sig_abcd,
   input wire logic cas_enable,
   output logic remote_alarm,
   output logic mf_align_lost,
   output logic irq_req
);
   import erai_pkg::*;

   logic [7:0] irq_en;
   logic [7:0] flag_en;
   logic [7:0] framing_control_reg;
   logic mfa_flag;
   logic spare_flag;
   logic sig_flag;
   logic ais_chg;
   logic yel_chg;
   logic ais_prev;
   logic a_prev;
   logic [4:0] sa_prev;
   logic sa_seen;
   logic [2:0] err_cnt;
   logic [2:0] thresh;
   logic [2:0] err_next;
   logic [NUM_CHAN-1:0] chg_vec;
   logic [31:0] chg_word;
   logic [3:0] sig_mem [NUM_CHAN];
   logic acc;
   logic wr_take;
   logic clr_status;
   logic clr_alarm;
   logic [NUM_SIG_REGS-1:0] clr_sig;
   logic ais_evt;
   logic yel_evt;
   logic spare_evt;
   logic mf_evt;
   logic sig_evt;
   logic chan_ok;
   logic [7:0] next_rdata;
   logic next_irq;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Request taken on the edge where waitrequest is still high
   assign acc = (avs_read | avs_write) & avs_waitrequest;
   assign wr_take = acc & avs_write & avs_byteenable[0];
   assign clr_status = acc & avs_read & (avs_address == IDX_STATUS);
   assign clr_alarm = acc & avs_read & (avs_address == IDX_ALARM);

   // Fixed one wait state keeps clear-on-read side effects single-shot
   always_ff @(posedge clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else if (!avs_waitrequest) begin
         avs_waitrequest <= 1'b1;
      end else if (avs_read | avs_write) begin
         avs_waitrequest <= 1'b0;
      end
   end
   a_bus_one_wait: assert property (acc |=>
      !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle after take");

   // Software-written control registers
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_en <= IRQ_EN_RST;
         flag_en <= FLAG_EN_RST;
         framing_control_reg <= FCR_RST;
      end else if (wr_take) begin
         if (avs_address == IDX_IRQ_EN) begin
            irq_en <= {6'h00, avs_writedata[BIT_AIS_EN:BIT_YEL_EN]};
         end
         if (avs_address == IDX_FLAG_EN) begin
            flag_en <= {avs_writedata[BIT_MFA:BIT_SIG], 5'h00};
         end
         if (avs_address == IDX_FCR) begin
            framing_control_reg <= avs_writedata[7:0];
         end
      end
   end
   a_ais_en_reset: assert property ($fell(rst) |->
      !irq_en[BIT_AIS_EN]) else $error("AIS enable not zero after reset");

   // Read data mux; unmapped indices read as zero
   always_comb begin
      next_rdata = 8'h00;
      clr_sig = '0;
      unique case (avs_address)
         IDX_IRQ_EN: next_rdata = irq_en;
         IDX_FLAG_EN: next_rdata = flag_en;
         IDX_FCR: next_rdata = framing_control_reg;
         IDX_STATUS: next_rdata = {mfa_flag, spare_flag, sig_flag, 5'h00};
         IDX_ALARM: next_rdata = {1'b0, mf_align_lost, ais_state,
                                  remote_alarm, 2'h0, ais_chg, yel_chg};
         default: begin
            if (avs_address >= IDX_SIG_CHG0
                && avs_address <= IDX_SIG_CHG3) begin
               next_rdata = chg_word[8*(avs_address - IDX_SIG_CHG0) +: 8];
            end
         end
      endcase
      for (int i = 0; i < NUM_SIG_REGS; i++) begin
         clr_sig[i] = acc & avs_read & (avs_address == IDX_SIG_CHG0 + 12'(i));
      end
   end

   // Read data captured with the answer
   always_ff @(posedge clk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (acc & avs_read) begin
         avs_readdata <= {24'h00_0000, next_rdata};
      end
   end

   // AIS change: both edges of the framer's AIS level count
   assign ais_evt = ais_state ^ ais_prev;
   always_ff @(posedge clk) begin
      if (rst) begin
         ais_prev <= 1'b0;
      end else begin
         ais_prev <= ais_state;
      end
   end

   // Yellow alarm: A bit must agree in two consecutive non-FAS frames
   assign yel_evt = nonfas_valid & (nonfas_a_bit == a_prev)
                    & (nonfas_a_bit != remote_alarm);
   always_ff @(posedge clk) begin
      if (rst) begin
         a_prev <= 1'b0;
         remote_alarm <= 1'b0;
      end else if (nonfas_valid) begin
         a_prev <= nonfas_a_bit;
         if (yel_evt) begin
            remote_alarm <= nonfas_a_bit;
         end
      end
   end
   a_yel_two_frames: assert property ($changed(remote_alarm) |->
      $past(nonfas_a_bit) == remote_alarm && $past(a_prev) == remote_alarm)
      else $error("yellow changed without two matching A bits");

   // Spare bits: first frame after reset only primes the history
   assign spare_evt = nonfas_valid & sa_seen & (nonfas_sa_bits != sa_prev);
   always_ff @(posedge clk) begin
      if (rst) begin
         sa_prev <= 5'h00;
         sa_seen <= 1'b0;
      end else if (nonfas_valid) begin
         sa_prev <= nonfas_sa_bits;
         sa_seen <= 1'b1;
      end
   end

   // Multiframe loss threshold: field value 0..3 means 1..4 errors
   assign thresh = {1'b0, framing_control_reg[FCR_THR_HI:FCR_THR_LO]} + 3'h1;
   assign err_next = err_cnt + 3'h1;
   assign mf_evt = mfas_valid & ((mfas_error & !mf_align_lost
                   & (err_next >= thresh)) | (!mfas_error & mf_align_lost));
   always_ff @(posedge clk) begin
      if (rst) begin
         err_cnt <= 3'h0;
         mf_align_lost <= 1'b0;
      end else if (mfas_valid) begin
         if (!mfas_error) begin
            err_cnt <= 3'h0;
            mf_align_lost <= 1'b0;
         end else if (!mf_align_lost) begin
            // Counter stops once loss is declared, so it cannot wrap
            err_cnt <= err_next;
            if (err_next >= thresh) begin
               mf_align_lost <= 1'b1;
            end
         end
      end
   end
   a_mf_threshold: assert property ($rose(mf_align_lost) |->
      $past(err_cnt) + 3'h1 >= $past(thresh) && $past(mfas_error))
      else $error("multiframe loss declared below threshold");

   // Signaling store; the change is only reported while CAS is on
   assign chan_ok = sig_valid & (sig_chan < 5'(NUM_CHAN));
   assign sig_evt = chan_ok & cas_enable
                    & (sig_abcd != sig_mem[sig_chan]);
   // Zero-padded to whole register bytes so the read mux never indexes out
   assign chg_word = {2'h0, chg_vec};
   generate
      for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
         // History keeps tracking even with CAS off, so no stale change
         always_ff @(posedge clk) begin
            if (rst) begin
               sig_mem[g] <= 4'h0;
            end else if (chan_ok && sig_chan == 5'(g)) begin
               sig_mem[g] <= sig_abcd;
            end
         end
         // Set wins over the read clear
         always_ff @(posedge clk) begin
            if (rst) begin
               chg_vec[g] <= 1'b0;
            end else begin
               chg_vec[g] <= (chg_vec[g] & !clr_sig[g/8])
                             | (sig_evt && sig_chan == 5'(g));
            end
         end
      end
   endgenerate
   a_sig_chan_mark: assert property (sig_evt |=>
      sig_flag && chg_vec[$past(sig_chan)])
      else $error("signaling change not recorded");
   a_sig_cas_off: assert property (!$past(cas_enable)
      && !$past(sig_flag) |-> !sig_flag)
      else $error("signaling flag set with CAS off");
   a_sig_reg_clear: assert property (clr_sig[0] && !sig_evt
      |=> chg_vec[7:0] == 8'h00)
      else $error("signaling change bits not cleared by read");

   // Sticky event flags; an event in the clearing cycle survives
   always_ff @(posedge clk) begin
      if (rst) begin
         mfa_flag <= 1'b0;
         spare_flag <= 1'b0;
         sig_flag <= 1'b0;
      end else begin
         mfa_flag <= (mfa_flag & !clr_status) | mf_evt;
         spare_flag <= (spare_flag & !clr_status) | spare_evt;
         sig_flag <= (sig_flag & !clr_status) | sig_evt;
      end
   end
   a_mfa_flag_set: assert property (mf_evt |=>
      mfa_flag && $changed(mf_align_lost))
      else $error("multiframe change flag missed");
   a_spare_flag_set: assert property (spare_evt |=> spare_flag)
      else $error("spare bits change flag missed");
   a_status_clear: assert property (clr_status
      && !mf_evt && !spare_evt && !sig_evt
      |=> !mfa_flag && !spare_flag && !sig_flag)
      else $error("status not cleared by read");

   // Alarm change flags; detection runs whatever the enables say
   always_ff @(posedge clk) begin
      if (rst) begin
         ais_chg <= 1'b0;
         yel_chg <= 1'b0;
      end else begin
         ais_chg <= (ais_chg & !clr_alarm) | ais_evt;
         yel_chg <= (yel_chg & !clr_alarm) | yel_evt;
      end
   end
   a_ais_change: assert property (ais_evt |=> ais_chg)
      else $error("AIS change not flagged");
   a_yel_change: assert property (yel_evt |=> yel_chg ##0
      remote_alarm == $past(nonfas_a_bit))
      else $error("yellow change not flagged");
   a_alarm_clear: assert property (clr_alarm && !ais_evt
      && !yel_evt |=> !ais_chg && !yel_chg)
      else $error("alarm changes not cleared by read");

   // Request follows the flags one cycle later
   assign next_irq = (ais_chg & irq_en[BIT_AIS_EN])
                     | (yel_chg & irq_en[BIT_YEL_EN])
                     | (mfa_flag & flag_en[BIT_MFA])
                     | (spare_flag & flag_en[BIT_SPARE])
                     | (sig_flag & flag_en[BIT_SIG]);
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_req <= 1'b0;
      end else begin
         irq_req <= next_irq;
      end
   end
   a_irq_masked: assert property (irq_en == 8'h00
      && flag_en == 8'h00 |=> !irq_req)
      else $error("request with all enables off");
   a_irq_ais_on: assert property (ais_chg && irq_en[BIT_AIS_EN]
      |=> irq_req) else $error("enabled AIS change gave no request");
   a_irq_flag_on: assert property (spare_flag && flag_en[BIT_SPARE]
      |=> irq_req) else $error("enabled spare change gave no request");
   a_irq_drop: assert property (!ais_chg && !yel_chg && !mfa_flag
      && !spare_flag && !sig_flag |=> !irq_req)
      else $error("request stayed with no flags");

endmodule : erai_top

// ### inc/erai_pkg.sv
// Constants for the E1 receive alarm and event interrupt block.
// Assumes one 40 MHz framer clock and word-addressed Avalon-MM access.
// How it works
// - AIS enable set means AIS declare and clear both raise an interrupt.
// - AIS enable is read/write and resets to zero.
// - Yellow enable set means yellow declare and clear raise interrupt.
// - Interrupt needs its enable; event detection runs regardless.
// - Multiframe alignment flag sets on loss declared or cleared, sticky.
// - Multiframe loss declared after threshold consecutive errored words.
// - Spare bits flag sets when any Sa4 to Sa8 value changes.
// - Signaling flag sets when any ABCD bit changes in 30 channels.
// - Per-channel change bits record which signaling channel changed.
// - Signaling flag only counts while channel associated signaling is on.
// - Status flags clear on read; one means event since last read.
// - Yellow declared on A=1 twice in a row, cleared on A=0 twice.
package erai_pkg;
   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_IRQ_EN = 12'hB03;
   localparam logic [11:0] IDX_STATUS = 12'hB04;
   localparam logic [11:0] IDX_ALARM = 12'hB10;
   localparam logic [11:0] IDX_FLAG_EN = 12'hB11;
   localparam logic [11:0] IDX_FCR = 12'h10B;
   localparam logic [11:0] IDX_SIG_CHG0 = 12'h10D;
   localparam logic [11:0] IDX_SIG_CHG3 = 12'h110;
   // Field positions
   localparam int BIT_YEL_EN = 0;
   localparam int BIT_AIS_EN = 1;
   localparam int BIT_SIG = 5;
   localparam int BIT_SPARE = 6;
   localparam int BIT_MFA = 7;
   localparam int BIT_YEL_CHG = 0;
   localparam int BIT_AIS_CHG = 1;
   localparam int BIT_YEL_ST = 4;
   localparam int BIT_AIS_ST = 5;
   localparam int BIT_MF_LOST = 6;
   localparam int FCR_THR_LO = 5;
   localparam int FCR_THR_HI = 6;
   // Sizes
   localparam int NUM_CHAN = 30;
   localparam int NUM_SIG_REGS = 4;
   // Values after reset
   localparam logic [7:0] IRQ_EN_RST = 8'h00;
   localparam logic [7:0] FLAG_EN_RST = 8'h00;
   localparam logic [7:0] FCR_RST = 8'h00;
endpackage : erai_pkg

// ### tb/erai_host.sv
// Avalon-MM master model standing in for the host processor.
// Assumes a slave that drops waitrequest for one cycle per access.
`timescale 1ns/1ps
module erai_host (
   input wire logic clk,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   output logic [11:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   output logic [3:0] byteenable
);
   // Idle bus from time zero; all byte lanes enabled
   initial begin
      address = 12'h000;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h00000000;
      byteenable = 4'hF;
   end

   // One transfer, held until waitrequest is sampled low; the bound
   // keeps a dead slave from hanging the run
   task automatic xfer(input logic w, input logic [11:0] a,
         input logic [7:0] d, output logic [31:0] q, output bit ok);
      int n;
      @(posedge clk);
      address <= a;
      read <= ~w;
      write <= w;
      writedata <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 64);
      ok = (waitrequest === 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : xfer
endmodule : erai_host

// ### tb/erai_top_test.sv
// Self-checking bench for the alarm and event interrupt block.
// Assumes erai_pkg and the host model are compiled first.
`timescale 1ns/1ps
module erai_top_test;
   import erai_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] adr;
   logic rd_s, wr_s, ais = 1'b0, nv = 1'b0, na = 1'b0, mv = 1'b0;
   logic me = 1'b0, sv = 1'b0, cas = 1'b0, wrq, ra, mfl, irq;
   logic [31:0] wd, rdat, q;
   logic [3:0] be, sa4 = 4'h0, v;
   logic [4:0] sab = 5'h00, sch = 5'h00, s;
   bit ok;
   int miscompares = 0;
   int comparisons = 0;
   int ch;

   always #12.5 clk = ~clk;

   erai_host host (.clk(clk), .readdata(rdat), .waitrequest(wrq),
      .address(adr), .read(rd_s), .write(wr_s), .writedata(wd),
      .byteenable(be));
   erai_top dut (.clk(clk), .rst(rst), .avs_address(adr),
      .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd),
      .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wrq),
      .ais_state(ais), .nonfas_valid(nv), .nonfas_a_bit(na),
      .nonfas_sa_bits(sab), .mfas_valid(mv), .mfas_error(me),
      .sig_valid(sv), .sig_chan(sch), .sig_abcd(sa4),
      .cas_enable(cas), .remote_alarm(ra), .mf_align_lost(mfl),
      .irq_req(irq));

   // Expected register index and bit of a signaling channel
   function automatic logic [11:0] sig_idx(input int c);
      return IDX_SIG_CHG0 + 12'(c / 8);
   endfunction : sig_idx
   function automatic logic [31:0] sig_mask(input int c);
      return 32'h1 << (c % 8);
   endfunction : sig_mask

   task automatic close_out;
      if (miscompares == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Register access; a timed-out bus counts as a miscompare
   task automatic acc(input logic w, input logic [11:0] a,
         input logic [7:0] d);
      host.xfer(w, a, d, q, ok);
      if (!ok) begin
         miscompares++;
         close_out();
      end
   endtask : acc

   task automatic frame(input logic a, input logic [4:0] sb);
      @(posedge clk);
      nv <= 1'b1;
      na <= a;
      sab <= sb;
      @(posedge clk);
      nv <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : frame

   task automatic mfa(input logic e);
      @(posedge clk);
      mv <= 1'b1;
      me <= e;
      @(posedge clk);
      mv <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : mfa

   task automatic sig(input int c, input logic [3:0] d);
      @(posedge clk);
      sv <= 1'b1;
      sch <= 5'(c);
      sa4 <= d;
      @(posedge clk);
      sv <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : sig

   // Toggle AIS and see irq follow the enable, then read the alarm reg
   task automatic ais_to(input logic l, input logic ie,
         input logic [31:0] ex);
      @(posedge clk);
      ais <= l;
      repeat (4) @(posedge clk);
      chk("irq_req", {31'h0, ie}, {31'h0, irq});
      acc(1'b0, IDX_ALARM, 8'h00);
      chk("alarm", ex, q);
      repeat (4) @(posedge clk);
      chk("irq_req", 32'h0, {31'h0, irq});
   endtask : ais_to

   initial begin
      void'($urandom(72));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      acc(1'b0, IDX_IRQ_EN, 8'h00);
      chk("irq_en", 32'h0, q);
      acc(1'b0, IDX_STATUS, 8'h00);
      chk("status", 32'h0, q);
      acc(1'b0, 12'h7FF, 8'h00);
      chk("unmapped", 32'h0, q);
      acc(1'b1, IDX_IRQ_EN, 8'hFF);
      acc(1'b0, IDX_IRQ_EN, 8'h00);
      chk("irq_en", 32'h3, q);
      ais_to(1'b1, 1'b1, 32'h22);
      ais_to(1'b0, 1'b1, 32'h02);
      acc(1'b1, IDX_IRQ_EN, 8'h01);
      ais_to(1'b1, 1'b0, 32'h22);
      // Yellow declare and clear, each with its own interrupt
      s = 5'($urandom);
      for (int i = 0; i < 2; i++) begin
         frame(~i[0], s);
         chk("remote", {31'h0, i[0]}, {31'h0, ra});
         frame(~i[0], s);
         chk("remote", {31'h0, ~i[0]}, {31'h0, ra});
         chk("irq_req", 32'h1, {31'h0, irq});
         acc(1'b0, IDX_ALARM, 8'h00);
         chk("alarm", i ? 32'h21 : 32'h31, q);
      end
      acc(1'b0, IDX_STATUS, 8'h00);
      chk("status", 32'h0, q);
      frame(1'b0, s ^ (5'h01 << $urandom_range(4)));
      acc(1'b0, IDX_STATUS, 8'h00);
      chk("status", 32'h40, q);
      // Every threshold code: loss after code+1 errors, clear on good
      for (int t = 0; t < 4; t++) begin
         acc(1'b1, IDX_FCR, {1'b0, 2'(t), 5'h00});
         repeat (t) mfa(1'b1);
         chk("mf_lost", 32'h0, {31'h0, mfl});
         mfa(1'b1);
         chk("mf_lost", 32'h1, {31'h0, mfl});
         acc(1'b0, IDX_STATUS, 8'h00);
         chk("status", 32'h80, q);
         mfa(1'b0);
         acc(1'b0, IDX_STATUS, 8'h00);
         chk("status", 32'h80, q);
      end
      // Signaling change on a random channel and on the last one
      cas <= 1'b1;
      v = 4'($urandom_range(14, 1));
      for (int i = 0; i < 2; i++) begin
         ch = i ? 29 : $urandom_range(28);
         sig(ch, i ? ~v : v);
         acc(1'b0, IDX_STATUS, 8'h00);
         chk("status", 32'h20, q);
         acc(1'b0, sig_idx(ch), 8'h00);
         chk("sig_chg", sig_mask(ch), q);
         acc(1'b0, sig_idx(ch), 8'h00);
         chk("sig_chg", 32'h0, q);
      end
      cas <= 1'b0;
      sig(29, v);
      acc(1'b0, IDX_STATUS, 8'h00);
      chk("status", 32'h0, q);
      cas <= 1'b1;
      sig(29, v);
      acc(1'b0, IDX_STATUS, 8'h00);
      chk("status", 32'h0, q);
      // Enabled status flag drives irq until read
      acc(1'b1, IDX_FLAG_EN, 8'hE0);
      frame(1'b0, ~s);
      chk("irq_req", 32'h1, {31'h0, irq});
      acc(1'b0, IDX_STATUS, 8'h00);
      chk("status", 32'h40, q);
      repeat (4) @(posedge clk);
      chk("irq_req", 32'h0, {31'h0, irq});
      close_out();
   end
endmodule : erai_top_test
